// ==== rtl/php_defs.vh ====
// constants for the parallel host port block
`ifndef PHP_DEFS_VH
`define PHP_DEFS_VH
// detected bus styles
`define PHP_MODE_NONE 3'h0
`define PHP_MODE_SEP_DED 3'h1
`define PHP_MODE_SEP_MUX 3'h2
`define PHP_MODE_COM_DED 3'h3
`define PHP_MODE_COM_MUX 3'h4
`define PHP_MODE_EPP 3'h5
// widths
`define PHP_DATA_W 8
`define PHP_ADDR_W 6
`define PHP_DED_ADDR_W 3
// internal reset phase length in core clocks
`define PHP_RESET_CYCLES 8'h10
// register reset value
`define PHP_REG_RESET 8'h00
`endif

// ==== rtl/php_sync.v ====
// two-flop synchroniser bank for pin inputs
`timescale 1ns/10ps
module php_sync #(
    parameter WIDTH = 1
) (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // asynchronous in, synchronous out
    input wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] stage1_q;
    reg [WIDTH-1:0] stage2_q;

    // first stage feeds only the second
    always @(posedge core_clk) begin
        if (!rst_n) begin
            stage1_q <= {WIDTH{1'b0}};
            stage2_q <= {WIDTH{1'b0}};
        end else begin
            stage1_q <= asyncIn;
            stage2_q <= stage1_q;
        end
    end

    assign syncOut = stage2_q;
endmodule

// ==== rtl/php_host_port.v ====
// parallel host port: bus style detection, strobes, address latch, register file
`timescale 1ns/10ps
`include "php_defs.vh"
module php_host_port #(
    parameter DATA_W = `PHP_DATA_W,
    parameter ADDR_W = `PHP_ADDR_W,
    parameter RESET_CYCLES = `PHP_RESET_CYCLES
) (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // reset/power-down pin
    input wire reset_powerdown_pin,
    // bus control pins
    input wire chip_select_low,
    input wire write_strobe_low,
    input wire read_strobe_low,
    input wire addr_strobe_high,
    // address pins; sep_addr_bit0 doubles as the EPP wait output
    input wire sep_addr_bit0,
    input wire sep_addr_bit1,
    input wire sep_addr_bit2,
    output wire waitLowOut,
    output wire waitLowOe,
    // data or multiplexed address/data pins
    input wire [DATA_W-1:0] dataIn,
    output wire [DATA_W-1:0] dataOut,
    output wire dataOe,
    // interrupt
    input wire irqEvent,
    output wire irqOut,
    // power control to the rest of the chip
    output wire oscStop,
    output wire padsDisconnect,
    output wire sinksOff,
    output wire internalResetActive,
    // detected bus style
    output wire [2:0] busMode
);
    // pin synchronisers
    wire [DATA_W+7:0] pinSync;
    php_sync #(
        .WIDTH(DATA_W + 8)
    ) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .asyncIn({reset_powerdown_pin, chip_select_low, write_strobe_low, read_strobe_low,
            addr_strobe_high, sep_addr_bit2, sep_addr_bit1, sep_addr_bit0, dataIn}),
        .syncOut(pinSync)
    );
    wire pdS = pinSync[DATA_W+7];
    wire csLowS = pinSync[DATA_W+6];
    wire wrLowS = pinSync[DATA_W+5];
    wire rdLowS = pinSync[DATA_W+4];
    wire asS = pinSync[DATA_W+3];
    wire a2S = pinSync[DATA_W+2];
    wire a1S = pinSync[DATA_W+1];
    wire a0S = pinSync[DATA_W];
    wire [DATA_W-1:0] busS = pinSync[DATA_W-1:0];

    // delayed copies for edge detection (read second-stage only)
    reg pd_q;
    reg wrLow_q;
    reg rdLow_q;
    reg as_q;
    always @(posedge core_clk) begin
        if (!rst_n) begin
            pd_q <= 1'b0;
            wrLow_q <= 1'b1;
            rdLow_q <= 1'b1;
            as_q <= 1'b0;
        end else begin
            pd_q <= pdS;
            wrLow_q <= wrLowS;
            rdLow_q <= rdLowS;
            as_q <= asS;
        end
    end

    // internal reset phase counter
    reg [7:0] rstCnt_q;
    wire pdFall = pd_q & ~pdS;
    always @(posedge core_clk) begin
        if (!rst_n) begin
            rstCnt_q <= 8'h00;
        end else if (pdS) begin
            rstCnt_q <= 8'h00;
        end else if (pdFall) begin
            rstCnt_q <= RESET_CYCLES;
        end else if (rstCnt_q != 8'h00) begin
            rstCnt_q <= rstCnt_q - 8'h01;
        end
    end
    // interface held idle while powered down or resetting
    wire hold = pdS | (rstCnt_q != 8'h00);
    assign oscStop = pdS;
    assign padsDisconnect = pdS;
    assign sinksOff = pdS;
    assign internalResetActive = rstCnt_q != 8'h00;

    // mode detection from static pin levels after reset
    reg [2:0] mode_q;
    function [2:0] php_detect;
        input as;
        input a2;
        input a1;
        input a0;
        input cs;
        input wr;
        input rd;
        begin
            if (as && a2 == 1'b0 && a1 == 1'b1 && a0 == 1'b1 && cs == 1'b0) begin
                php_detect = `PHP_MODE_SEP_MUX;
            end else if (a2 == 1'b1 && a1 == 1'b1 && cs == 1'b0) begin
                // handshake wiring: stay undecided until the address strobe falls,
                // so the wait pin is not driven before the host asks for it
                // limitation: a dedicated-bus host parked at address 6 or 7 waits too
                php_detect = `PHP_MODE_NONE;
            end else if (as && a2 == 1'b0 && a1 == 1'b1 && a0 == 1'b0) begin
                php_detect = `PHP_MODE_COM_MUX;
            end else if (as && wr && !rd) begin
                // data strobe low with write idle: only a common strobe idles this way
                php_detect = `PHP_MODE_COM_DED;
            end else if (as) begin
                php_detect = `PHP_MODE_SEP_DED;
            end else begin
                php_detect = `PHP_MODE_NONE;
            end
        end
    endfunction

    // mode is cleared in reset and learned once select is seen low, or on a falling address strobe at address 6 or 7
    always @(posedge core_clk) begin
        if (!rst_n || hold) begin
            mode_q <= `PHP_MODE_NONE;
        end else if (mode_q == `PHP_MODE_NONE && as_q && !asS && a2S && a1S) begin
            // only a falling strobe counts; the rise out of the reset flops is no edge
            mode_q <= `PHP_MODE_EPP;
        end else if (mode_q == `PHP_MODE_NONE && !csLowS) begin
            mode_q <= php_detect(asS, a2S, a1S, a0S, csLowS, wrLowS, rdLowS);
        end
    end
    assign busMode = mode_q;

    wire isSep = mode_q == `PHP_MODE_SEP_DED || mode_q == `PHP_MODE_SEP_MUX;
    wire isCom = mode_q == `PHP_MODE_COM_DED || mode_q == `PHP_MODE_COM_MUX;
    wire isEpp = mode_q == `PHP_MODE_EPP;
    wire isMux = mode_q == `PHP_MODE_SEP_MUX || mode_q == `PHP_MODE_COM_MUX || isEpp;

    // address latch; transparent while the strobe holds it open
    reg [ADDR_W-1:0] addr_q;
    always @(posedge core_clk) begin
        if (!rst_n || hold) begin
            addr_q <= {ADDR_W{1'b0}};
        end else if (mode_q == `PHP_MODE_SEP_MUX && asS) begin
            addr_q <= busS[ADDR_W-1:0];
        end else if (mode_q == `PHP_MODE_COM_MUX && asS) begin
            addr_q <= busS[ADDR_W-1:0];
        end else if (isEpp && !asS && wrLowS == 1'b0) begin
            // only address writes: an address strobe with write high is ignored
            addr_q <= busS[ADDR_W-1:0];
        end
    end
    // dedicated modes use the three address pins
    wire [ADDR_W-1:0] dedAddr = {{(ADDR_W-3){1'b0}}, a2S, a1S, a0S};
    wire [ADDR_W-1:0] curAddr = isMux ? addr_q : dedAddr;

    // strobe decode per bus style
    // in EPP the select pin inhibits the data strobe; boards tie it low otherwise
    wire selOk = !csLowS;
    wire dsLowNow = rdLowS;
    wire dsLowOld = rdLow_q;
    wire wrStart = selOk && (isSep ? (wrLow_q && !wrLowS) :
        ((isCom || isEpp) && dsLowOld && !dsLowNow && !wrLowS));
    wire rdActive = selOk && (isSep ? !rdLowS :
        ((isCom || isEpp) && !dsLowNow && wrLowS));
    wire dsActive = selOk && (isCom || isEpp) && !dsLowNow;

    // register storage, flip-flops indexed by address
    localparam DEPTH = 1 << ADDR_W;
    reg [DATA_W-1:0] regs_q [0:DEPTH-1];
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_reg
            always @(posedge core_clk) begin
                if (!rst_n) begin
                    regs_q[gi] <= `PHP_REG_RESET;
                end else if (wrStart && !hold && curAddr == gi) begin
                    // data already stable for two clocks before the strobe edge is seen
                    regs_q[gi] <= busS;
                end
            end
        end
    endgenerate

    // read data register and bus enable
    reg [DATA_W-1:0] rdData_q;
    reg rdOe_q;
    always @(posedge core_clk) begin
        if (!rst_n || hold) begin
            rdData_q <= {DATA_W{1'b0}};
            rdOe_q <= 1'b0;
        end else begin
            rdData_q <= regs_q[curAddr];
            rdOe_q <= rdActive;
        end
    end
    assign dataOut = rdData_q;
    assign dataOe = rdOe_q && !pdS;

    // EPP wait handshake: low while the strobe is unanswered, high once served
    reg waitLow_q;
    reg waitEn_q;
    always @(posedge core_clk) begin
        if (!rst_n || hold) begin
            waitLow_q <= 1'b1;
            waitEn_q <= 1'b0;
        end else begin
            if (isEpp) begin
                waitEn_q <= 1'b1;
            end
            // wait drops when idle, rises once the access has been served
            waitLow_q <= dsActive || (isEpp && !asS) ? 1'b1 : 1'b0;
        end
    end
    assign waitLowOut = waitLow_q;
    assign waitLowOe = waitEn_q && !pdS;

    // interrupt request follows internal events, registered
    reg irq_q;
    always @(posedge core_clk) begin
        if (!rst_n || hold) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irqEvent;
        end
    end
    assign irqOut = irq_q;
endmodule

// ==== verif/php_host_model.sv ====
// host side wire model for the shared data and wait lines
`timescale 1ns/10ps
module php_host_model (
    // device side
    input wire [7:0] devData,
    input wire devOe,
    input wire waitOut,
    input wire waitOe,
    // host side
    input wire [7:0] hostData,
    input wire hostOe,
    input wire hostBit0,
    // resolved wires
    output wire [7:0] busData,
    output wire bit0Wire
);
    // a released bus shows the inverse, never a stale copy
    assign busData = devOe ? devData : hostOe ? hostData : ~hostData;
    assign bit0Wire = waitOe ? waitOut : hostBit0;
endmodule

// ==== verif/php_host_port_sva.sv ====
// assertions on the parallel host port pins
`timescale 1ns/10ps
`include "php_defs.vh"
module php_host_port_sva #(
    parameter RESET_CYCLES = 16
) (
    input wire core_clk,
    input wire rst_n,
    input wire reset_powerdown_pin,
    input wire chip_select_low,
    input wire write_strobe_low,
    input wire read_strobe_low,
    input wire waitLowOut,
    input wire waitLowOe,
    input wire dataOe,
    input wire irqEvent,
    input wire irqOut,
    input wire oscStop,
    input wire padsDisconnect,
    input wire sinksOff,
    input wire internalResetActive,
    input wire [2:0] busMode
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    reg [7:0] runLen_q;
    // length of the running reset phase
    always @(posedge core_clk) begin
        runLen_q <= (!rst_n || !internalResetActive) ? 8'h00 : runLen_q + 8'h01;
    end
    a_pd_stops_all: assert property (reset_powerdown_pin[*4] |=> oscStop && padsDisconnect && sinksOff)
        else $error("power down not applied");
    a_pd_release: assert property (!reset_powerdown_pin[*4] |=> !oscStop && !padsDisconnect)
        else $error("power down not released");
    a_phase_start: assert property ($fell(padsDisconnect) |-> ##[0:3] internalResetActive)
        else $error("reset phase missing");
    a_phase_len: assert property ($fell(internalResetActive) |-> runLen_q == RESET_CYCLES)
        else $error("reset phase length wrong");
    a_cs_gates_oe: assert property (chip_select_low[*6] |-> !dataOe)
        else $error("bus driven while deselected");
    a_idle_no_oe: assert property (read_strobe_low[*6] |-> !dataOe)
        else $error("bus driven with no read");
    a_read_drives: assert property ($fell(read_strobe_low) && !chip_select_low && write_strobe_low
        && (busMode == `PHP_MODE_SEP_DED || busMode == `PHP_MODE_EPP) |-> ##[2:5] dataOe)
        else $error("read not answered");
    a_oe_cause: assert property ($rose(dataOe) |-> !$past(read_strobe_low, 2) && $past(write_strobe_low, 2))
        else $error("bus driven without read cycle");
    a_wait_hiz: assert property (busMode == `PHP_MODE_NONE |-> !waitLowOe)
        else $error("wait driven before handshake mode");
    a_mode_cleared: assert property (!$past(rst_n) |-> busMode == `PHP_MODE_NONE)
        else $error("mode not cleared by reset");
    a_irq_follow: assert property ($past(rst_n) && !$past(oscStop) && !$past(internalResetActive)
        |-> irqOut == $past(irqEvent))
        else $error("interrupt request not following event");
    a_wait_strobe: assert property ((busMode == `PHP_MODE_EPP && !read_strobe_low
        && !chip_select_low)[*4] |-> waitLowOut)
        else $error("wait low during data strobe");
endmodule
bind php_host_port php_host_port_sva #(.RESET_CYCLES(RESET_CYCLES)) u_php_host_port_sva (
    .core_clk, .rst_n, .reset_powerdown_pin, .chip_select_low, .write_strobe_low,
    .read_strobe_low, .waitLowOut, .waitLowOe, .dataOe, .irqEvent, .irqOut, .oscStop,
    .padsDisconnect, .sinksOff, .internalResetActive, .busMode);

// ==== verif/test_parallel_host_port_pins.sv ====
// self-checking bench for the parallel host port
`timescale 1ns/10ps
`include "php_defs.vh"
module test_parallel_host_port_pins;
    reg clk = 0, rstN = 0, pd = 0, cs = 1, wr = 1, rd = 1, as = 1, irq = 0, hOe = 0;
    reg [2:0] ad = 0;
    reg [7:0] hd = 0;
    reg [7:0] wd [0:7];
    reg [31:0] lfsr = 32'd87078;
    reg [7:0] expQ [$];
    integer fails = 0, n_checks = 0, i;
    wire [7:0] dOut, bus;
    wire dOe, wOut, wOe, irqOut, osc, pads, sinks, irA, b0;
    wire [2:0] mode;
    php_host_port #(.RESET_CYCLES(8'h10)) u_php_host_port (.core_clk(clk), .rst_n(rstN),
        .reset_powerdown_pin(pd), .chip_select_low(cs), .write_strobe_low(wr),
        .read_strobe_low(rd), .addr_strobe_high(as), .sep_addr_bit0(b0),
        .sep_addr_bit1(ad[1]), .sep_addr_bit2(ad[2]), .waitLowOut(wOut), .waitLowOe(wOe),
        .dataIn(bus), .dataOut(dOut), .dataOe(dOe), .irqEvent(irq), .irqOut(irqOut),
        .oscStop(osc), .padsDisconnect(pads), .sinksOff(sinks), .internalResetActive(irA),
        .busMode(mode));
    php_host_model u_php_host_model (.devData(dOut), .devOe(dOe), .waitOut(wOut),
        .waitOe(wOe), .hostData(hd), .hostOe(hOe), .hostBit0(ad[0]), .busData(bus),
        .bit0Wire(b0));
    initial begin
        forever #5 clk = ~clk;
    end
    function [31:0] nextRand(input [31:0] s);
        nextRand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // free-running random source, also toggles the event input
    always @(negedge clk) begin
        lfsr <= nextRand(lfsr);
        irq <= lfsr[0];
    end
    task check(input [7:0] seen, input [7:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task final_report;
        if (fails == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge clk);
    endtask
    // one data cycle; strobes held well past the synchroniser lag
    task xfer(input rdCyc, input epp, input [7:0] d);
        hd = d;
        hOe = !rdCyc;
        wr = rdCyc | !epp;
        if (rdCyc)
            expQ.push_back(d);
        cyc(4);
        if (rdCyc | epp)
            rd = 0;
        else
            wr = 0;
        cyc(8);
        if (epp)
            check(b0, 8'h01);
        rd = 1;
        wr = 1;
        cyc(6);
        hOe = 0;
    endtask
    // handshake address write, upper two bits must be ignored
    task eppAddr(input [7:0] a);
        hd = a;
        hOe = 1;
        wr = 0;
        cyc(4);
        as = 0;
        cyc(8);
        as = 1;
        wr = 1;
        cyc(6);
        hOe = 0;
    endtask
    // read answers against the oldest note
    always @(posedge dOe) begin
        @(negedge clk);
        check(dOut, expQ.pop_front());
    end
    initial begin
        #100000;
        fails = fails + 1;
        final_report;
    end
    initial begin
        cyc(20);
        rstN = 1;
        cyc(4);
        check(mode, `PHP_MODE_NONE);
        check(wOe, 8'h00);
        cs = 0;
        cyc(4);
        check(mode, `PHP_MODE_SEP_DED);
        for (i = 0; i < 8; i = i + 1) begin
            ad = i;
            wd[i] = lfsr[15:8];
            xfer(0, 0, wd[i]);
        end
        // deselected write must be ignored
        cs = 1;
        ad = 3;
        xfer(0, 0, ~wd[3]);
        cs = 0;
        for (i = 0; i < 8; i = i + 1) begin
            ad = i;
            xfer(1, 0, wd[i]);
        end
        pd = 1;
        cyc(6);
        check(osc & pads & sinks, 8'h01);
        check(irqOut, 8'h00);
        pd = 0;
        cyc(4);
        check(irA, 8'h01);
        cyc(20);
        check(irA, 8'h00);
        // hard reset into handshake style, select tied low
        rstN = 0;
        ad = 3'h6;
        cyc(4);
        rstN = 1;
        cyc(4);
        eppAddr(8'hD5);
        check(mode, `PHP_MODE_EPP);
        check(wOe, 8'h01);
        xfer(0, 1, 8'hA5);
        eppAddr(8'h2A);
        xfer(0, 1, 8'h3C);
        eppAddr(8'h15);
        xfer(1, 1, 8'hA5);
        eppAddr(8'hEA);
        xfer(1, 1, 8'h3C);
        cyc(10);
        final_report;
    end
endmodule
